// >>> mac_command_config_control_tb.sv
// Self-checking testbench of the MAC command block
`include "mcc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mac_command_config_control_tb;
  localparam int QC = 8;
  localparam logic [31:0] VCMD [0:11] = '{32'h2, 32'h12, 32'h2, 32'h82, 32'h2, 32'h800002,
    32'h4000002, 32'h2, 32'h4000002, 32'h5000002, 32'h4000002, 32'h2};
  // Flags: match, pause, control, length, error, overflow, store-forward; odd rows keep
  localparam logic [6:0] VFLG [0:11] = '{7'h00, 7'h00, 7'h70, 7'h70, 7'h50, 7'h50,
    7'h45, 7'h45, 7'h49, 7'h49, 7'h43, 7'h43};
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        pv = 1'b0;
  logic        eof = 1'b0;
  logic        go = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [15:0] pq = 16'h0;
  logic [6:0]  rxf = 7'h00;
  logic [31:0] rdat, v;
  logic [15:0] quanta;
  logic        wreq, busy, tx_on, rx_on, pad_sh, sa_ow, s_pad, s_fcs, c_len;
  logic        fl_tx, fl_rx, clr_st, p_send, halt, vval, vkeep, lb;
  logic [63:0] cl_txd, cl_rxd, phy_rxd, phy_txd, ptd, prd;
  logic [7:0]  cl_txc, cl_rxc, phy_rxc, phy_txc, ptc, prc;
  int          errors = 0;
  int          n_compared = 0;

  always #12.5 mclk = ~mclk;

  mcc_command #(.QUANTUM_CYCLES(QC)) u_dut
  (
    .MCLK(mclk), .RESET_N(reset_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .TX_PATH_ON(tx_on),
    .RX_PATH_ON(rx_on), .TX_PAD_SHORT(pad_sh), .TX_OVERWRITE_SA(sa_ow), .RX_STRIP_PAD(s_pad),
    .RX_STRIP_FCS(s_fcs), .RX_CHECK_LENGTH(c_len), .FLUSH_TX_FIFO(fl_tx),
    .FLUSH_RX_FIFO(fl_rx), .CLEAR_STATS(clr_st), .PAUSE_SEND(p_send), .PAUSE_QUANTA(quanta),
    .RX_PAUSE_VALID(pv), .RX_PAUSE_QUANTA(pq), .TX_HALT(halt), .RX_EOF(eof),
    .RX_DA_MATCH(rxf[6]), .RX_IS_PAUSE(rxf[5]), .RX_IS_CONTROL(rxf[4]),
    .RX_LEN_MISMATCH(rxf[3]), .RX_FRAME_ERR(rxf[2]), .RX_OVERFLOW(rxf[1]),
    .RX_STORE_FWD(rxf[0]), .RX_VERDICT_VALID(vval), .RX_VERDICT_KEEP(vkeep),
    .CL_TXD(cl_txd), .CL_TXC(cl_txc), .CL_RXD(cl_rxd), .CL_RXC(cl_rxc), .PHY_RXD(phy_rxd),
    .PHY_RXC(phy_rxc), .PHY_TXD(phy_txd), .PHY_TXC(phy_txc), .LOOPBACK_ACTIVE(lb)
  );

  mcc_far_end u_far
  (
    .clk(mclk), .rst_n(reset_n), .start(go), .busy(busy), .cl_txd(cl_txd),
    .cl_txc(cl_txc), .phy_rxd(phy_rxd), .phy_rxc(phy_rxc)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic close_out;
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the edge that samples waitrequest low; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
      errors++;
    @(posedge mclk);
    v = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic at(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic pulse_go;
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask

  // Loopback takes the client words; otherwise each path carries its own side
  task automatic paths(input logic lbk, input int n);
    @(negedge mclk);
    repeat (n)
    begin
      {ptc, ptd} = {cl_txc, cl_txd};
      {prc, prd} = {phy_rxc, phy_rxd};
      @(negedge mclk);
      chk({cl_rxc, cl_rxd}, lbk ? {ptc, ptd} : {prc, prd});
      chk({phy_txc, phy_txd}, lbk ? {`MCC_IDLE_C, `MCC_IDLE_D} : {ptc, ptd});
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    bus(1'b0, `MCC_OFF_CMD, 32'h0);
    chk(v, 32'h0);
    chk({pad_sh, s_fcs, c_len, tx_on, rx_on}, 5'b11100);
  endtask

  task automatic t_bits;
    bus(1'b1, `MCC_OFF_CMD, 32'hffffdfff);
    bus(1'b0, `MCC_OFF_CMD, 32'h0);
    chk(v, 32'h05c083f7);
    at(1);
    chk({tx_on, rx_on, sa_ow, s_pad, s_fcs, c_len}, 6'b111110);
    bus(1'b1, 8'h04, 32'h1234);
    bus(1'b0, 8'h04, 32'h0);
    chk(v, 32'h0);
    bus(1'b1, `MCC_OFF_CMD, 32'h40);
    at(1);
    chk({s_fcs, s_pad, pad_sh, sa_ow}, 4'b0010);
    bus(1'b1, `MCC_OFF_CMD, 32'h60);
    at(1);
    chk({s_fcs, s_pad, pad_sh}, 3'b111);
  endtask

  task automatic t_pause_out;
    bus(1'b1, `MCC_OFF_QUANT, 32'h1234);
    bus(1'b1, `MCC_OFF_CMD, 32'h400000);
    at(1);
    chk({p_send, quanta}, 17'h11234);
    bus(1'b1, `MCC_OFF_CMD, 32'h400004);
    at(1);
    chk({p_send, quanta}, 17'h10000);
    bus(1'b1, `MCC_OFF_CMD, 32'h0);
    at(1);
    chk(p_send, 1'b0);
  endtask

  task automatic t_pause_in(input logic ign);
    int n;
    n = 0;
    bus(1'b1, `MCC_OFF_CMD, {23'h0, ign, 8'h00});
    @(posedge mclk);
    pv <= 1'b1;
    pq <= 16'h0002;
    @(posedge mclk);
    pv <= 1'b0;
    @(negedge mclk);
    while (halt === 1'b1 && n < 100)
    begin
      n++;
      @(negedge mclk);
    end
    chk(n, ign ? 0 : 2 * QC);
  endtask

  task automatic t_verdict;
    for (int i = 0; i < 12; i++)
    begin
      bus(1'b1, `MCC_OFF_CMD, VCMD[i]);
      @(posedge mclk);
      eof <= 1'b1;
      rxf <= VFLG[i];
      @(posedge mclk);
      eof <= 1'b0;
      @(negedge mclk);
      chk({vval, vkeep}, {1'b1, i[0]});
    end
  endtask

  task automatic t_loop;
    int n;
    n = 0;
    pulse_go();
    bus(1'b1, `MCC_OFF_CMD, 32'h8000);
    while (busy === 1'b1 && n < 20)
    begin
      @(negedge mclk);
      chk(lb, 1'b0);
      n++;
    end
    at(4);
    chk(lb, 1'b1);
    bus(1'b0, `MCC_OFF_STATUS, 32'h0);
    chk(v, 32'h1);
    pulse_go();
    paths(1'b1, 8);
    bus(1'b1, `MCC_OFF_CMD, 32'h0);
    at(4);
    chk(lb, 1'b0);
    pulse_go();
    paths(1'b0, 8);
  endtask

  task automatic t_restart;
    int n;
    n = 0;
    bus(1'b1, `MCC_OFF_QUANT, 32'hab);
    bus(1'b1, `MCC_OFF_CMD, 32'h2003);
    while (fl_tx !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    chk({fl_tx, fl_rx, clr_st, tx_on, rx_on}, 5'b11100);
    n = 0;
    while (fl_tx === 1'b1 && n < 100)
    begin
      n++;
      @(negedge mclk);
    end
    chk(n, `MCC_RESTART_CYC);
    bus(1'b0, `MCC_OFF_CMD, 32'h0);
    chk(v, 32'h0);
    bus(1'b0, `MCC_OFF_QUANT, 32'h0);
    chk(v, 32'hab);
  endtask

  initial
  begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_bits();
    t_pause_out();
    t_pause_in(1'b0);
    t_pause_in(1'b1);
    t_verdict();
    t_loop();
    t_restart();
    close_out();
  end

  // Whole run needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire

// >>> mcc_command.sv
// MAC command word, register slave, pause control, loopback mux and receive verdict
//
// Behaviour
// - Transmit enable bit; cleared by any reset
// - Receive enable bit; cleared by any reset
// - Pause-off request sends zero-quanta pause
// - Accept-all skips destination address check
// - Pad stripping removes receive padding
// - Short transmit frames always padded
// - Keep-FCS bit chooses deliver or strip CRC
// - Pad stripping forces CRC strip
// - Pass-pause forwards pause frames, else dropped
// - Disregard-pause ignores quanta, else transmit halts
// - Overwrite source address on transmit when set
// - Soft restart disables paths, flushes, clears stats
// - Soft restart bit self-clears when done
// - Loopback routes transmit into receive
// - Loopback switches only between frames
// - Idles sent to network during loopback
// - Programmed pause sends pause time quanta
// - Pass-control delivers non-pause control frames
// - Skip-length-check disables payload length compare
// - Store-forward drops errored or overflowed frames
// - Soft restart keeps config, flushes both FIFOs
`include "mcc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mcc_command
#(
  parameter int QUANTUM_CYCLES = 8
)
(
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output var  logic [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             TX_PATH_ON,
  output logic             RX_PATH_ON,
  output logic             TX_PAD_SHORT,
  output logic             TX_OVERWRITE_SA,
  output logic             RX_STRIP_PAD,
  output logic             RX_STRIP_FCS,
  output logic             RX_CHECK_LENGTH,
  output logic             FLUSH_TX_FIFO,
  output logic             FLUSH_RX_FIFO,
  output logic             CLEAR_STATS,
  output var  logic        PAUSE_SEND,
  output var  logic [15:0] PAUSE_QUANTA,
  input  wire logic        RX_PAUSE_VALID,
  input  wire logic [15:0] RX_PAUSE_QUANTA,
  output var  logic        TX_HALT,
  input  wire logic        RX_EOF,
  input  wire logic        RX_DA_MATCH,
  input  wire logic        RX_IS_PAUSE,
  input  wire logic        RX_IS_CONTROL,
  input  wire logic        RX_LEN_MISMATCH,
  input  wire logic        RX_FRAME_ERR,
  input  wire logic        RX_OVERFLOW,
  input  wire logic        RX_STORE_FWD,
  output var  logic        RX_VERDICT_VALID,
  output var  logic        RX_VERDICT_KEEP,
  input  wire logic [63:0] CL_TXD,
  input  wire logic [7:0]  CL_TXC,
  output var  logic [63:0] CL_RXD,
  output var  logic [7:0]  CL_RXC,
  input  wire logic [63:0] PHY_RXD,
  input  wire logic [7:0]  PHY_RXC,
  output var  logic [63:0] PHY_TXD,
  output var  logic [7:0]  PHY_TXC,
  output logic             LOOPBACK_ACTIVE
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic has_term(input logic [63:0] d, input logic [7:0] c);
    logic t;
    t = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (c[i] && d[8*i +: 8] == `MCC_TERM_CH)
        t = 1'b1;
    end
    return t;
  endfunction

  logic [31:0]       cmd;
  logic [15:0]       quant;
  logic              ack;
  logic              req;
  logic              fire;
  mcc_pkg::mcc_rs_t  rs_state;
  logic [4:0]        rs_cnt;
  logic              rs_done;
  logic              in_frame;
  logic              sof;
  logic              eof;
  logic              frame_busy;
  logic              loop_active;
  logic [15:0]       halt_cnt;
  logic [15:0]       sub_cnt;
  logic              bad;
  logic              next_keep;

  // ------------------------------------------------------------
  // Register slave: one wait cycle, then the answer
  // ------------------------------------------------------------
  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign fire            = req & ack;

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      ack <= 1'b0;
    else
      ack <= req & ~ack;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      AVS_READDATA <= 32'h00000000;
    else if (AVS_READ && !ack)
    begin
      case (AVS_ADDRESS)
        `MCC_OFF_CMD:    AVS_READDATA <= cmd & `MCC_CMD_MASK;
        `MCC_OFF_QUANT:  AVS_READDATA <= {16'h0000, quant};
        `MCC_OFF_STATUS: AVS_READDATA <= {28'h0000000, in_frame, TX_HALT,
                                          rs_state == mcc_pkg::RS_RUN, loop_active};
        default:         AVS_READDATA <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Command word
  // ------------------------------------------------------------
  // Restart forcing comes last so a write during the sequence cannot re-enable the paths
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      cmd <= `MCC_CMD_RST;
    else
    begin
      if (rs_done)
        cmd[`MCC_B_RESTART] <= 1'b0;
      if (fire && AVS_WRITE && AVS_ADDRESS == `MCC_OFF_CMD)
        cmd <= AVS_WRITEDATA & `MCC_CMD_MASK;
      if (rs_state == mcc_pkg::RS_RUN || cmd[`MCC_B_RESTART])
      begin
        cmd[`MCC_B_TXON] <= 1'b0;
        cmd[`MCC_B_RXON] <= 1'b0;
      end
    end
  end

  // Pause time register is configuration and survives a soft restart
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      quant <= `MCC_QUANT_RST;
    else if (fire && AVS_WRITE && AVS_ADDRESS == `MCC_OFF_QUANT)
      quant <= AVS_WRITEDATA[15:0];
  end

  // ------------------------------------------------------------
  // Soft restart sequence
  // ------------------------------------------------------------
  assign rs_done = (rs_state == mcc_pkg::RS_RUN) && (rs_cnt == 5'h00);

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      rs_state <= mcc_pkg::RS_IDLE;
      rs_cnt   <= 5'h00;
    end
    else
    begin
      case (rs_state)
        mcc_pkg::RS_IDLE:
          if (cmd[`MCC_B_RESTART])
          begin
            rs_state <= mcc_pkg::RS_RUN;
            rs_cnt   <= 5'(`MCC_RESTART_CYC - 1);
          end
        mcc_pkg::RS_RUN:
          if (rs_cnt == 5'h00)
            rs_state <= mcc_pkg::RS_IDLE;
          else
            rs_cnt <= rs_cnt - 5'h01;
        default:
          rs_state <= mcc_pkg::RS_IDLE;
      endcase
    end
  end

  assign FLUSH_TX_FIFO = rs_state == mcc_pkg::RS_RUN;
  assign FLUSH_RX_FIFO = rs_state == mcc_pkg::RS_RUN;
  assign CLEAR_STATS   = rs_state == mcc_pkg::RS_RUN;

  // ------------------------------------------------------------
  // Static datapath controls
  // ------------------------------------------------------------
  assign TX_PATH_ON      = cmd[`MCC_B_TXON];
  assign RX_PATH_ON      = cmd[`MCC_B_RXON];
  assign TX_PAD_SHORT    = 1'b1;
  assign TX_OVERWRITE_SA = cmd[`MCC_B_SAINS];
  assign RX_STRIP_PAD    = cmd[`MCC_B_PAD];
  assign RX_STRIP_FCS    = cmd[`MCC_B_PAD] | ~cmd[`MCC_B_KEEPFCS];
  assign RX_CHECK_LENGTH = ~cmd[`MCC_B_NOLEN];

  // ------------------------------------------------------------
  // Pause generation and received pause timer
  // ------------------------------------------------------------
  // Pause-off wins when both requests stand, so the link is never left stalled
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      PAUSE_SEND   <= 1'b0;
      PAUSE_QUANTA <= 16'h0000;
    end
    else
    begin
      PAUSE_SEND   <= cmd[`MCC_B_XON] | cmd[`MCC_B_XOFF];
      PAUSE_QUANTA <= cmd[`MCC_B_XON] ? 16'h0000 : quant;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      halt_cnt <= 16'h0000;
      sub_cnt  <= 16'h0000;
    end
    else if (RX_PAUSE_VALID && !cmd[`MCC_B_IGNPS])
    begin
      halt_cnt <= RX_PAUSE_QUANTA;
      sub_cnt  <= 16'(QUANTUM_CYCLES - 1);
    end
    else if (halt_cnt != 16'h0000)
    begin
      if (sub_cnt == 16'h0000)
      begin
        halt_cnt <= halt_cnt - 16'h0001;
        sub_cnt  <= 16'(QUANTUM_CYCLES - 1);
      end
      else
        sub_cnt <= sub_cnt - 16'h0001;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      TX_HALT <= 1'b0;
    else if (RX_PAUSE_VALID && !cmd[`MCC_B_IGNPS])
      TX_HALT <= RX_PAUSE_QUANTA != 16'h0000;
    else
      TX_HALT <= (halt_cnt > 16'h0001) || (halt_cnt == 16'h0001 && sub_cnt != 16'h0000);
  end

  // ------------------------------------------------------------
  // Receive verdict at end of frame
  // ------------------------------------------------------------
  assign bad = RX_FRAME_ERR | RX_OVERFLOW | (RX_LEN_MISMATCH & ~cmd[`MCC_B_NOLEN]);

  always_comb
  begin
    next_keep = cmd[`MCC_B_RXON];
    if (!cmd[`MCC_B_PROMIS] && !RX_DA_MATCH)
      next_keep = 1'b0;
    if (RX_IS_PAUSE && !cmd[`MCC_B_PASSPS])
      next_keep = 1'b0;
    if (RX_IS_CONTROL && !RX_IS_PAUSE && !cmd[`MCC_B_PASSCTL])
      next_keep = 1'b0;
    if (cmd[`MCC_B_DROPBAD] && RX_STORE_FWD && bad)
      next_keep = 1'b0;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      RX_VERDICT_VALID <= 1'b0;
      RX_VERDICT_KEEP  <= 1'b0;
    end
    else
    begin
      RX_VERDICT_VALID <= RX_EOF;
      if (RX_EOF)
        RX_VERDICT_KEEP <= next_keep;
    end
  end

  // ------------------------------------------------------------
  // Loopback at the media-independent interface
  // ------------------------------------------------------------
  assign sof        = CL_TXC[0] && CL_TXD[7:0] == `MCC_START_CH;
  assign eof        = has_term(CL_TXD, CL_TXC);
  assign frame_busy = in_frame | sof;

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      in_frame <= 1'b0;
    else if (sof && !eof)
      in_frame <= 1'b1;
    else if (eof)
      in_frame <= 1'b0;
  end

  // The mode only moves while no frame is on the transmit side
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      loop_active <= 1'b0;
    else if (!frame_busy)
      loop_active <= cmd[`MCC_B_LOOP];
  end

  assign LOOPBACK_ACTIVE = loop_active;

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      PHY_TXD <= `MCC_IDLE_D;
      PHY_TXC <= `MCC_IDLE_C;
      CL_RXD  <= `MCC_IDLE_D;
      CL_RXC  <= `MCC_IDLE_C;
    end
    else if (loop_active)
    begin
      PHY_TXD <= `MCC_IDLE_D;
      PHY_TXC <= `MCC_IDLE_C;
      CL_RXD  <= CL_TXD;
      CL_RXC  <= CL_TXC;
    end
    else
    begin
      PHY_TXD <= CL_TXD;
      PHY_TXC <= CL_TXC;
      CL_RXD  <= PHY_RXD;
      CL_RXC  <= PHY_RXC;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  a_restart_paths_off: assert property (
    rs_state == mcc_pkg::RS_RUN |-> !TX_PATH_ON && !RX_PATH_ON && FLUSH_RX_FIFO)
    else $error("path enabled during soft restart");

  a_restart_self_clear: assert property (
    rs_done |=> !cmd[`MCC_B_RESTART] || $past(fire && AVS_WRITE))
    else $error("restart bit not cleared at end");

  a_restart_start: assert property (
    rs_state == mcc_pkg::RS_IDLE && cmd[`MCC_B_RESTART] |=> FLUSH_TX_FIFO && $stable(quant))
    else $error("restart did not flush or lost pause time");

  a_xon_zero_quanta: assert property (
    cmd[`MCC_B_XON] |=> PAUSE_SEND && PAUSE_QUANTA == 16'h0000)
    else $error("pause-off request sent nonzero quanta");

  a_xoff_quanta: assert property (
    cmd[`MCC_B_XOFF] && !cmd[`MCC_B_XON] |=> PAUSE_SEND && PAUSE_QUANTA == $past(quant))
    else $error("programmed pause quanta wrong");

  a_pause_halts: assert property (
    RX_PAUSE_VALID && !cmd[`MCC_B_IGNPS] && RX_PAUSE_QUANTA != 16'h0000 |=> TX_HALT)
    else $error("received pause did not halt transmit");

  a_pause_dropped: assert property (
    RX_EOF && RX_IS_PAUSE && !cmd[`MCC_B_PASSPS] |=> RX_VERDICT_VALID && !RX_VERDICT_KEEP)
    else $error("pause frame delivered");

  a_bad_dropped: assert property (
    RX_EOF && RX_STORE_FWD && RX_OVERFLOW && cmd[`MCC_B_DROPBAD] |=> !RX_VERDICT_KEEP)
    else $error("bad frame kept in store-forward");

  a_fcs_forced: assert property (
    cmd[`MCC_B_PAD] |-> RX_STRIP_FCS)
    else $error("CRC kept while pad stripping");

  a_loop_between: assert property (
    loop_active != $past(loop_active) |-> !$past(frame_busy))
    else $error("loopback switched inside a frame");

  a_loop_idle: assert property (
    loop_active |=> PHY_TXC == `MCC_IDLE_C && PHY_TXD == `MCC_IDLE_D)
    else $error("traffic sent to network in loopback");

  a_loop_route: assert property (
    loop_active |=> CL_RXD == $past(CL_TXD) && CL_RXC == $past(CL_TXC))
    else $error("loopback data not routed");

  a_reserved_zero: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `MCC_OFF_CMD
      |-> (AVS_READDATA & ~`MCC_CMD_MASK) == 32'h00000000)
    else $error("reserved command bits read nonzero");

  c_restart: cover property (rs_done);
  c_loop_enter: cover property (!$past(loop_active) && loop_active);
  c_halt: cover property (TX_HALT ##1 !TX_HALT);
  c_keep: cover property (RX_VERDICT_VALID && RX_VERDICT_KEEP);

endmodule

`default_nettype wire

// >>> mcc_far_end.sv
// Far-side model: client transmit frames and a network receive stream
`include "mcc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mcc_far_end
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  output var  logic        busy,
  output var  logic [63:0] cl_txd,
  output var  logic [7:0]  cl_txc,
  output var  logic [63:0] phy_rxd,
  output var  logic [7:0]  phy_rxc
);
  logic [2:0] idx;
  logic [7:0] pat;

  // ------------------------------------------------------------
  // Frame sequencer: start, four data words, terminate
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      idx  <= 3'h0;
    end
    else if (busy)
    begin
      idx  <= idx + 3'h1;
      busy <= (idx != 3'h5);
    end
    else if (start)
    begin
      busy <= 1'b1;
      idx  <= 3'h0;
    end
  end

  // Pattern moves every cycle, so a stale word never passes for a fresh one
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pat <= 8'h00;
    else
      pat <= pat + 8'h01;
  end

  always_comb
  begin
    cl_txd = `MCC_IDLE_D;
    cl_txc = `MCC_IDLE_C;
    if (busy && idx == 3'h0)
    begin
      cl_txd = {{7{8'h55}}, `MCC_START_CH};
      cl_txc = 8'h01;
    end
    else if (busy && idx == 3'h5)
    begin
      cl_txd = {{7{8'h07}}, `MCC_TERM_CH};
      cl_txc = 8'hff;
    end
    else if (busy)
    begin
      cl_txd = {8{pat}};
      cl_txc = 8'h00;
    end
  end

  assign phy_rxd = {8{~pat}};
  assign phy_rxc = 8'h00;
endmodule
`default_nettype wire

// >>> mcc_map.svh
// Register offsets, field positions, reset values and timing counts of the command block
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define MCC_OFF_STATUS 8'h00
`define MCC_OFF_CMD    8'h08
`define MCC_OFF_QUANT  8'h18

// ------------------------------------------------------------
// Command word fields
// ------------------------------------------------------------
`define MCC_B_TXON     0
`define MCC_B_RXON     1
`define MCC_B_XON      2
`define MCC_B_PROMIS   4
`define MCC_B_PAD      5
`define MCC_B_KEEPFCS  6
`define MCC_B_PASSPS   7
`define MCC_B_IGNPS    8
`define MCC_B_SAINS    9
`define MCC_B_RESTART  13
`define MCC_B_LOOP     15
`define MCC_B_XOFF     22
`define MCC_B_PASSCTL  23
`define MCC_B_NOLEN    24
`define MCC_B_DROPBAD  26
`define MCC_CMD_MASK   32'h05c0a3f7

// ------------------------------------------------------------
// Reset values, link characters and timing
// ------------------------------------------------------------
`define MCC_CMD_RST    32'h00000000
`define MCC_QUANT_RST  16'h0000
`define MCC_IDLE_D     64'h0707070707070707
`define MCC_IDLE_C     8'hff
`define MCC_START_CH   8'hfb
`define MCC_TERM_CH    8'hfd
`define MCC_CLK_NS     25
`define MCC_RESTART_NS 400
`define MCC_RESTART_CYC ((`MCC_RESTART_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)

`endif

// >>> mcc_pkg.sv
// Types shared by the command block
package mcc_pkg;
  typedef enum logic [0:0]
  {
    RS_IDLE = 1'b0,
    RS_RUN  = 1'b1
  } mcc_rs_t;
endpackage
